// ---- rdd_decoder.sv ----
`timescale 1ns/1ps
// Behaviour
// - mode field selects one of sixteen portions
// - modifier bits zero: function from original word
// - unassigned function raises unimplemented fault
// - group 00 nonzero copies register into A
// - group 01 passes six single-bit I/O values
// - 80 loads data switches into A
// - field addressing values condition field addressing
// - 8A-8E condition general-register next word
// - listed values condition multiple-register next word
// - 9E sets floating mode bit
// - listed group 10 values raise fault
// - group 11 honours only nine values
// - three values copy status word unchanged
// - copy status then clear external inhibit
// - copy status then clear internal inhibit
// - copy status then clear both inhibits
// - copy status then set external inhibit
// - copy status then set internal inhibit
// - copy status then set both inhibits
// - non-indicator status bits copy as zero
// - load word fills register chosen by code
// - no interrupt between two sequence words
module rdd_decoder (
	input  wire logic                clk_i,
	input  wire logic                sys_rst_i,
	input  wire rdd_pkg::rdd_instr_t instr_i,
	input  wire logic [15:0]         psd_i,
	input  wire logic [15:0]         data_switch_i,
	input  wire logic [3:0]          avs_address_i,
	input  wire logic                avs_read_i,
	input  wire logic                avs_write_i,
	input  wire logic [31:0]         avs_writedata_i,
	input  wire logic [3:0]          avs_byteenable_i,
	output logic [31:0]              avs_readdata_o,
	output logic                     avs_waitrequest_o,
	output logic                     a_load_o,
	output logic [15:0]              a_data_o,
	output logic                     src_copy_o,
	output logic [5:0]               source_register_code_o,
	output logic                     iop_op_o,
	output logic                     field_cond_o,
	output logic                     multi_cond_o,
	output logic [7:0]               func_o,
	output logic                     gr_write_o,
	output logic [2:0]               target_register_code_o,
	output logic [15:0]              gr_data_o,
	output logic                     seq_hold_o,
	output logic                     fault_o,
	output logic                     other_mode_o,
	output logic [3:0]               mode_o,
	output logic                     ext_inh_o,
	output logic                     int_inh_o,
	output logic                     float_mode_o
);

	// ***************************************
	// decode of the dispatched word
	// ***************************************
	rdd_pkg::rdd_st_t st_q;
	rdd_pkg::rdd_st_t st_d;
	logic             direct;
	logic             go;
	logic [3:0]       dec_mode;
	logic [7:0]       dec_func;
	logic [2:0]       dec_code;
	logic             is_field;
	logic             is_gr;
	logic             is_multi;
	logic             is_iop;
	logic [15:0]      psd_word;
	logic             av_req;

	// effective mode and function selection
	assign direct   = (instr_i.word[11:8] == 4'h0);
	assign dec_mode = direct ? rdd_pkg::RDD_MODE_INTERNAL : instr_i.eff[11:8];
	assign dec_func = direct ? instr_i.word[7:0] : instr_i.eff[7:0];
	assign dec_code = dec_func[2:0];
	assign go       = instr_i.valid && (st_q.state == rdd_pkg::RDD_IDLE)
		&& (instr_i.word[15:12] == rdd_pkg::RDD_OPC_READ_DIRECT);

	// function classes of groups 10 and 01
	assign is_field = (dec_func[7:6] == 2'b10)
		&& (dec_func[3:0] inside {4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hF})
		&& !(dec_func inside {8'h80, 8'h81, 8'h87});
	assign is_gr    = (dec_func[7:3] == rdd_pkg::RDD_GR_PREFIX)
		&& (dec_code >= rdd_pkg::RDD_GR_CODE_LO)
		&& (dec_code <= rdd_pkg::RDD_GR_CODE_HI);
	assign is_multi = dec_func inside {[8'h92:8'h96], [8'h9A:8'h9D], [8'hA2:8'hA4],
		8'hAA, 8'hAB, 8'hB2};
	assign is_iop   = (dec_func[7:6] == 2'b01) && ($countones(dec_func[5:0]) == 1);

	// status word as seen by software, spare bits zero
	always_comb begin
		psd_word = psd_i & rdd_pkg::RDD_PSD_IND_MASK;
		psd_word[rdd_pkg::RDD_PSD_FM_BIT] = st_q.fm;
		psd_word[rdd_pkg::RDD_PSD_II_BIT] = st_q.ii;
		psd_word[rdd_pkg::RDD_PSD_EI_BIT] = st_q.ei;
	end

	assign av_req = avs_read_i || avs_write_i;

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		st_d            = st_q;
		st_d.sw_meta    = data_switch_i;
		st_d.sw_sync    = st_q.sw_meta;
		st_d.a_load     = 1'b0;
		st_d.src_copy   = 1'b0;
		st_d.iop_op     = 1'b0;
		st_d.field_cond = 1'b0;
		st_d.multi_cond = 1'b0;
		st_d.gr_write   = 1'b0;
		st_d.fault      = 1'b0;
		st_d.other_mode = 1'b0;
		case (st_q.state)
			rdd_pkg::RDD_IDLE: begin
				if (go && (dec_mode != rdd_pkg::RDD_MODE_INTERNAL)) begin
					// hand over to interrupt, direct I/O or special equipment
					st_d.other_mode = 1'b1;
					st_d.mode       = dec_mode;
					st_d.func       = dec_func;
				end else if (go) begin
					st_d.mode = dec_mode;
					st_d.func = dec_func;
					case (dec_func[7:6])
						2'b00: begin
							if (dec_func == rdd_pkg::RDD_FN_NONE) begin
								st_d.fault = 1'b1;
							end else begin
								st_d.src_copy = 1'b1;
								st_d.src_code = dec_func[5:0];
							end
						end
						2'b01: begin
							if (is_iop) begin
								st_d.iop_op = 1'b1;
							end else begin
								st_d.fault = 1'b1;
							end
						end
						2'b10: begin
							if (dec_func == rdd_pkg::RDD_FN_SWITCHES) begin
								st_d.a_load = 1'b1;
								st_d.a_data = st_q.sw_sync;
							end else if (is_field && st_q.options[rdd_pkg::RDD_OPT_FIELD_BIT]) begin
								st_d.field_cond = 1'b1;
							end else if (is_gr && st_q.options[rdd_pkg::RDD_OPT_GENREG_BIT]) begin
								// next word runs on the coded register, interrupts held off
								st_d.state   = rdd_pkg::RDD_GR_AWAIT;
								st_d.gr_code = dec_code;
								st_d.hold    = 1'b1;
							end else if (is_multi) begin
								st_d.multi_cond = 1'b1;
							end else if ((dec_func == rdd_pkg::RDD_FN_FLOAT_MODE)
								&& st_q.options[rdd_pkg::RDD_OPT_FLOAT_BIT]) begin
								st_d.fm = 1'b1;
							end else begin
								st_d.fault = 1'b1;
							end
						end
						default: begin
							// group 11: copy status word into A, then alter inhibits
							st_d.a_load = 1'b1;
							st_d.a_data = psd_word;
							case (dec_func)
								rdd_pkg::RDD_FN_PSD_PLAIN_A,
								rdd_pkg::RDD_FN_PSD_PLAIN_B,
								rdd_pkg::RDD_FN_PSD_PLAIN_C: begin
									st_d.ei = st_q.ei;
								end
								rdd_pkg::RDD_FN_PSD_EI_CLR: begin
									st_d.ei = 1'b0;
								end
								rdd_pkg::RDD_FN_PSD_II_CLR: begin
									st_d.ii = 1'b0;
								end
								rdd_pkg::RDD_FN_PSD_BOTH_CLR: begin
									st_d.ei = 1'b0;
									st_d.ii = 1'b0;
								end
								rdd_pkg::RDD_FN_PSD_EI_SET: begin
									st_d.ei = 1'b1;
								end
								rdd_pkg::RDD_FN_PSD_II_SET: begin
									st_d.ii = 1'b1;
								end
								rdd_pkg::RDD_FN_PSD_BOTH_SET: begin
									st_d.ei = 1'b1;
									st_d.ii = 1'b1;
								end
								default: begin
									st_d.a_load = 1'b0;
									st_d.a_data = st_q.a_data; // refused value leaves A data alone
									st_d.fault  = 1'b1;
								end
							endcase
						end
					endcase
					if (st_d.fault) begin
						st_d.fault_func = dec_func;
					end
				end
			end
			rdd_pkg::RDD_GR_AWAIT: begin
				// second word: load word writes the operand to the coded register
				if (instr_i.valid) begin
					st_d.state = rdd_pkg::RDD_IDLE;
					st_d.hold  = 1'b0;
					if (instr_i.word[15:12] == rdd_pkg::RDD_OPC_LOAD_WORD) begin
						st_d.gr_write = 1'b1;
						st_d.gr_data  = instr_i.operand;
					end
				end
			end
			default: begin
				st_d.state = rdd_pkg::RDD_IDLE;
				st_d.hold  = 1'b0;
			end
		endcase

		// bus slave: one wait cycle, then the answer edge
		if (av_req && st_q.av_wait) begin
			st_d.av_wait = 1'b0;
			case (avs_address_i)
				rdd_pkg::RDD_REG_OPTIONS: st_d.av_rdata = {29'h0, st_q.options};
				rdd_pkg::RDD_REG_STATUS:  st_d.av_rdata = {26'h0, st_q.state, st_q.hold, st_q.fm, st_q.ii, st_q.ei};
				rdd_pkg::RDD_REG_FAULT:   st_d.av_rdata = {24'h0, st_q.fault_func};
				default:                  st_d.av_rdata = 32'h0;
			endcase
		end else begin
			st_d.av_wait = 1'b1;
		end
		if (avs_write_i && !st_q.av_wait && (avs_address_i == rdd_pkg::RDD_REG_OPTIONS)
			&& avs_byteenable_i[0]) begin
			st_d.options = avs_writedata_i[2:0];
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q         <= '0;
			st_q.state   <= rdd_pkg::RDD_IDLE;
			st_q.options <= rdd_pkg::RDD_OPTIONS_RST;
			st_q.av_wait <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ***************************************
	// outputs
	// ***************************************
	assign avs_readdata_o         = st_q.av_rdata;
	assign avs_waitrequest_o      = st_q.av_wait;
	assign a_load_o               = st_q.a_load;
	assign a_data_o               = st_q.a_data;
	assign src_copy_o             = st_q.src_copy;
	assign source_register_code_o = st_q.src_code;
	assign iop_op_o               = st_q.iop_op;
	assign field_cond_o           = st_q.field_cond;
	assign multi_cond_o           = st_q.multi_cond;
	assign func_o                 = st_q.func;
	assign gr_write_o             = st_q.gr_write;
	assign target_register_code_o = st_q.gr_code;
	assign gr_data_o              = st_q.gr_data;
	assign seq_hold_o             = st_q.hold;
	assign fault_o                = st_q.fault;
	assign other_mode_o           = st_q.other_mode;
	assign mode_o                 = st_q.mode;
	assign ext_inh_o              = st_q.ei;
	assign int_inh_o              = st_q.ii;
	assign float_mode_o           = st_q.fm;

	// ***************************************
	// checks
	// ***************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_rd0(logic [7:0] f);
		go && (dec_mode == 4'h0) && (dec_func == f);
	endsequence

	sequence s_prefix;
		go && (dec_mode == 4'h0) && is_gr && st_q.options[1];
	endsequence

	a_mode_select: assert property (go && (dec_mode != 4'h0) |=> other_mode_o && (mode_o == $past(dec_mode)))
		else $error("mode not handed over");
	a_direct_func: assert property (go && (instr_i.word[11:0] == 12'h080) |=> a_load_o && (a_data_o == $past(st_q.sw_sync)))
		else $error("direct switch read lost");
	a_zero_fault: assert property (s_rd0(8'h00) |=> fault_o && !src_copy_o && (func_o == 8'h00))
		else $error("function zero not faulted");
	a_iop_pass: assert property (go && (dec_mode == 4'h0) && (dec_func[7:6] == 2'b01) |=> (iop_op_o != fault_o))
		else $error("io group decode wrong");
	a_unassigned_ten: assert property (s_rd0(8'h85) or s_rd0(8'hBA) |=> fault_o)
		else $error("unassigned value executed");
	a_psd_mask: assert property (s_rd0(8'hC0) |=> a_load_o && ((a_data_o & ~16'h00F3) == 16'h0000))
		else $error("spare status bits not zero");
	a_ei_clear: assert property (s_rd0(8'hE4) |=> !ext_inh_o && (a_data_o[4] == $past(st_q.ei)))
		else $error("external inhibit not cleared");
	a_both_set: assert property (s_rd0(8'hFC) |=> ext_inh_o && int_inh_o)
		else $error("inhibits not both set");
	a_float_set: assert property (go && (dec_mode == 4'h0) && (dec_func == 8'h9E) && st_q.options[2]
		|=> float_mode_o && !fault_o)
		else $error("floating mode not set");
	a_seq_hold: assert property (s_prefix |=> seq_hold_o && (target_register_code_o == $past(dec_code)))
		else $error("prefix did not hold interrupts");
	a_load_word: assert property (seq_hold_o && instr_i.valid && (instr_i.word[15:12] == 4'h8)
		|=> gr_write_o && !seq_hold_o && (gr_data_o == $past(instr_i.operand)))
		else $error("load word not written");
	a_top_fault: assert property (s_rd0(8'hC4) |=> fault_o && !a_load_o)
		else $error("top group value not refused");

	// second word of an open general-register sequence
	sequence s_second;
		seq_hold_o && instr_i.valid;
	endsequence

	// a refused word has no effect beyond the fault pulse
	a_fault_quiet: assert property (fault_o |-> !a_load_o && !src_copy_o && !iop_op_o && !field_cond_o
		&& !multi_cond_o && !gr_write_o && $stable(a_data_o))
		else $error("faulted word had an effect");
	a_io_zero: assert property (s_rd0(8'h40) |=> fault_o && !iop_op_o)
		else $error("io group value forty not refused");

	// sequence open: nothing else happens until the second word
	a_seq_close: assert property (s_second |=> !seq_hold_o)
		else $error("sequence not closed by second word");
	a_hold_quiet: assert property (seq_hold_o |-> !a_load_o && !fault_o && !other_mode_o && !gr_write_o)
		else $error("activity while sequence open");
	a_prefix_quiet: assert property (s_prefix |=> !fault_o && !a_load_o)
		else $error("prefix raised an effect");
	a_bad_code: assert property (go && (dec_mode == 4'h0) && (dec_func == 8'h88) && !st_q.options[0]
		|=> fault_o && !seq_hold_o)
		else $error("bad register code not refused");

	// group classes of the read-direct function
	a_src_copy: assert property (go && (dec_mode == 4'h0) && (dec_func[7:6] == 2'b00) && (dec_func != 8'h00)
		|=> src_copy_o && ({2'b00, source_register_code_o} == $past(dec_func)))
		else $error("register copy not issued");
	a_io_func: assert property (go && (dec_mode == 4'h0) && is_iop |=> iop_op_o && (func_o == $past(dec_func)))
		else $error("io function not passed");
	a_field_cond: assert property (go && (dec_mode == 4'h0) && is_field && st_q.options[0]
		|=> field_cond_o && !fault_o)
		else $error("field addressing not conditioned");
	a_multi_cond: assert property (go && (dec_mode == 4'h0) && is_multi |=> multi_cond_o && !fault_o)
		else $error("multiple register not conditioned");
	a_other_quiet: assert property (go && (dec_mode != 4'h0) |=> !fault_o && !a_load_o)
		else $error("other mode decoded here");

	// status word copies and inhibit changes
	a_plain_copy: assert property (s_rd0(8'hE0) |=> a_load_o && $stable(ext_inh_o) && $stable(int_inh_o))
		else $error("plain copy altered inhibits");
	a_ii_clear: assert property (s_rd0(8'hE8) |=> !int_inh_o && (a_data_o[5] == $past(st_q.ii)))
		else $error("internal inhibit not cleared");
	a_both_clear: assert property (s_rd0(8'hEC) |=> !ext_inh_o && !int_inh_o)
		else $error("inhibits not both cleared");
	a_ei_set: assert property (s_rd0(8'hF4) |=> ext_inh_o && a_load_o)
		else $error("external inhibit not set");
	a_ii_set: assert property (s_rd0(8'hF8) |=> int_inh_o && a_load_o)
		else $error("internal inhibit not set");

endmodule

// ---- rdd_pkg.sv ----
package rdd_pkg;

	// ***************************************
	// instruction encoding
	// ***************************************
	localparam logic [3:0]  RDD_OPC_READ_DIRECT = 4'h1;
	localparam logic [3:0]  RDD_OPC_LOAD_WORD   = 4'h8;
	localparam logic [3:0]  RDD_MODE_INTERNAL   = 4'h0;
	localparam logic [7:0]  RDD_FN_NONE         = 8'h00;
	localparam logic [7:0]  RDD_FN_SWITCHES     = 8'h80;
	localparam logic [7:0]  RDD_FN_FLOAT_MODE   = 8'h9E;
	localparam logic [4:0]  RDD_GR_PREFIX       = 5'h11;
	localparam logic [2:0]  RDD_GR_CODE_LO      = 3'h2;
	localparam logic [2:0]  RDD_GR_CODE_HI      = 3'h6;

	// status word copy functions
	localparam logic [7:0]  RDD_FN_PSD_PLAIN_A  = 8'hC0;
	localparam logic [7:0]  RDD_FN_PSD_PLAIN_B  = 8'hE0;
	localparam logic [7:0]  RDD_FN_PSD_PLAIN_C  = 8'hF0;
	localparam logic [7:0]  RDD_FN_PSD_EI_CLR   = 8'hE4;
	localparam logic [7:0]  RDD_FN_PSD_II_CLR   = 8'hE8;
	localparam logic [7:0]  RDD_FN_PSD_BOTH_CLR = 8'hEC;
	localparam logic [7:0]  RDD_FN_PSD_EI_SET   = 8'hF4;
	localparam logic [7:0]  RDD_FN_PSD_II_SET   = 8'hF8;
	localparam logic [7:0]  RDD_FN_PSD_BOTH_SET = 8'hFC;

	// ***************************************
	// status word layout (word bit = 15 - doc bit)
	// ***************************************
	localparam logic [15:0] RDD_PSD_IND_MASK    = 16'h00F3;
	localparam int          RDD_PSD_FM_BIT      = 6;
	localparam int          RDD_PSD_II_BIT      = 5;
	localparam int          RDD_PSD_EI_BIT      = 4;

	// ***************************************
	// register map
	// ***************************************
	localparam logic [3:0]  RDD_REG_OPTIONS     = 4'h0;
	localparam logic [3:0]  RDD_REG_STATUS      = 4'h4;
	localparam logic [3:0]  RDD_REG_FAULT       = 4'h8;
	localparam logic [2:0]  RDD_OPTIONS_RST     = 3'h7;
	localparam int          RDD_OPT_FIELD_BIT   = 0;
	localparam int          RDD_OPT_GENREG_BIT  = 1;
	localparam int          RDD_OPT_FLOAT_BIT   = 2;

	typedef enum logic [1:0] {
		RDD_IDLE     = 2'b01,
		RDD_GR_AWAIT = 2'b10
	} rdd_state_t;

	// one dispatched instruction word
	typedef struct packed {
		logic        valid;
		logic [15:0] word;
		logic [15:0] eff;
		logic [15:0] operand;
	} rdd_instr_t;

	typedef struct packed {
		rdd_state_t  state;
		logic [15:0] sw_meta;
		logic [15:0] sw_sync;
		logic        ei;
		logic        ii;
		logic        fm;
		logic [2:0]  options;
		logic [7:0]  fault_func;
		logic [2:0]  gr_code;
		logic        a_load;
		logic [15:0] a_data;
		logic        src_copy;
		logic [5:0]  src_code;
		logic        iop_op;
		logic        field_cond;
		logic        multi_cond;
		logic [7:0]  func;
		logic        gr_write;
		logic [15:0] gr_data;
		logic        hold;
		logic        fault;
		logic        other_mode;
		logic [3:0]  mode;
		logic        av_wait;
		logic [31:0] av_rdata;
	} rdd_st_t;

endpackage

// ---- rdd_fetch_model.sv ----
`timescale 1ns/1ps
// fetch side: one instruction word per send cycle, stale fields hidden
module rdd_fetch_model (
	input  wire logic           clk_i,
	input  wire logic           send_i,
	input  wire logic [15:0]    word_i,
	input  wire logic [15:0]    eff_i,
	input  wire logic [15:0]    operand_i,
	output rdd_pkg::rdd_instr_t instr_o
);
	logic [47:0] last_q = '0;

	// remember the last word sent
	always @(posedge clk_i) begin
		if (send_i)
			last_q <= {word_i, eff_i, operand_i};
	end

	// idle cycles show the inverse, never the old word
	always_comb begin
		instr_o.valid = send_i;
		{instr_o.word, instr_o.eff, instr_o.operand} = send_i ? {word_i, eff_i, operand_i} : ~last_q;
	end
endmodule

// ---- read_direct_mode0_decoder_tb.sv ----
`timescale 1ns/1ps
module read_direct_mode0_decoder_tb;
	// ****
	// harness
	// ****
	logic                clk_i = 1'h0;
	logic                sys_rst_i = 1'h1;
	rdd_pkg::rdd_instr_t instr_i;
	logic [15:0]         psd_i = '0, data_switch_i = '0, a_data_o, gr_data_o, exp_a;
	logic [15:0]         s_word = '0, s_eff = '0, s_op = '0;
	logic [3:0]          avs_address_i = '0, avs_byteenable_i = '0, mode_o;
	logic                avs_read_i = 1'h0, avs_write_i = 1'h0, snd = 1'h0;
	logic [31:0]         avs_writedata_i = '0, avs_readdata_o, rd;
	logic                avs_waitrequest_o, a_load_o, src_copy_o, iop_op_o, field_cond_o, multi_cond_o;
	logic                gr_write_o, seq_hold_o, fault_o, other_mode_o, ext_inh_o, int_inh_o, float_mode_o;
	logic [5:0]          source_register_code_o;
	logic [7:0]          func_o, c;
	logic [2:0]          target_register_code_o;
	logic                ei = 1'h0, ii = 1'h0, fm = 1'h0;
	int                  err_count = 0, checks_done = 0;

	rdd_decoder uut (.clk_i, .sys_rst_i, .instr_i, .psd_i, .data_switch_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .a_load_o,
		.a_data_o, .src_copy_o, .source_register_code_o, .iop_op_o, .field_cond_o, .multi_cond_o, .func_o,
		.gr_write_o, .target_register_code_o, .gr_data_o, .seq_hold_o, .fault_o, .other_mode_o, .mode_o,
		.ext_inh_o, .int_inh_o, .float_mode_o);

	rdd_fetch_model fetch (.clk_i, .send_i(snd), .word_i(s_word), .eff_i(s_eff), .operand_i(s_op),
		.instr_o(instr_i));

	// 125 MHz clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// ****
	// tasks
	// ****
	// expected class {fault, aload, src, iop, field, multi, genreg, float}
	function automatic logic [7:0] cls(input logic [7:0] f);
		cls = 8'h80;
		case (f[7:6])
			2'h0: if (f != 8'h00) cls = 8'h20;
			2'h1: if (f inside {8'h41, 8'h42, 8'h44, 8'h48, 8'h50, 8'h60}) cls = 8'h10;
			2'h2: begin
				if (f == 8'h80) cls = 8'h40;
				else if (f inside {[8'h81:8'h87], 8'hA5, 8'hA6, [8'hAC:8'hAE], [8'hB3:8'hB6], [8'hBA:8'hBE]}) cls = 8'h80;
				else if (f[3:0] inside {4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hF}) cls = 8'h08;
				else if (f inside {[8'h8A:8'h8E]}) cls = 8'h02;
				else if (f == 8'h9E) cls = 8'h01;
				else cls = 8'h04;
			end
			default: if (f inside {8'hC0, 8'hE0, 8'hF0, 8'hE4, 8'hE8, 8'hEC, 8'hF4, 8'hF8, 8'hFC}) cls = 8'h40;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge clk_i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'h0 && n < 20);
		rd = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
		if (avs_waitrequest_o !== 1'h0) begin
			err_count++;
			end_of_test();
		end
	endtask

	// dispatch one word; keep holds valid for a chained word
	task automatic issue(input logic [15:0] w, input logic [15:0] e, input logic [15:0] op, input logic keep);
		if (!snd) @(posedge clk_i);
		snd <= 1'h1;
		s_word <= w;
		s_eff <= e;
		s_op <= op;
		psd_i <= 16'($urandom);
		@(posedge clk_i);
		if (!keep) snd <= 1'h0;
	endtask

	// ****
	// sequence
	// ****
	initial begin
		void'($urandom(47));
		data_switch_i <= 16'($urandom);
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		@(negedge clk_i);
		chk({avs_waitrequest_o, ext_inh_o, int_inh_o, float_mode_o, seq_hold_o}, 32'h10);
		bus(1'h0, rdd_pkg::RDD_REG_OPTIONS, 32'h0, 4'hF);
		chk(rd, 32'h7);
		bus(1'h0, rdd_pkg::RDD_REG_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h10);
		bus(1'h0, 4'hC, 32'h0, 4'hF);
		chk(rd, 32'h0);
		// every function value coded in the original word, effective word random
		for (int f = 0; f < 256; f++) begin
			c = cls(f[7:0]);
			issue({8'h10, f[7:0]}, 16'($urandom), 16'h0, 1'h0);
			@(negedge clk_i);
			exp_a = f == 128 ? data_switch_i : (psd_i & rdd_pkg::RDD_PSD_IND_MASK & 16'hFF8F) | {9'h0, fm, ii, ei, 4'h0};
			chk({fault_o, a_load_o, src_copy_o, iop_op_o, field_cond_o, multi_cond_o, seq_hold_o}, c[7:1]);
			if (c[6]) chk(a_data_o, exp_a);
			if (c[5]) chk(source_register_code_o, f[5:0]);
			if (c[4]) chk(func_o, f);
			if (c[6] && f[7:6] == 2'h3) begin
				if (f[2]) ei = f[4];
				if (f[3]) ii = f[4];
				chk({ext_inh_o, int_inh_o}, {ei, ii});
			end
			if (c[0]) fm = 1'h1;
			chk(float_mode_o, fm);
			if (c[1]) begin
				chk(target_register_code_o, f[2:0]);
				exp_a = 16'($urandom);
				issue(16'h8000, 16'($urandom), exp_a, 1'h0);
				@(negedge clk_i);
				chk({gr_write_o, seq_hold_o, gr_data_o}, {1'h1, 1'h0, exp_a});
			end
		end
		// modes 1 to F handed out
		for (int m = 1; m < 16; m++) begin
			issue(16'h1300, {4'h0, m[3:0], 8'hFF}, 16'h0, 1'h0);
			@(negedge clk_i);
			chk({other_mode_o, fault_o, mode_o}, {1'h1, 1'h0, m[3:0]});
		end
		// modifier set: function comes from the effective word
		issue(16'h1500, 16'h0080, 16'h0, 1'h0);
		@(negedge clk_i);
		chk({a_load_o, fault_o, a_data_o}, {1'h1, 1'h0, data_switch_i});
		// prefix and load word back to back
		exp_a = 16'($urandom);
		issue(16'h108B, 16'h0, 16'h0, 1'h1);
		fork
			issue(16'h8000, 16'h0, exp_a, 1'h0);
			begin
				@(negedge clk_i);
				chk({seq_hold_o, target_register_code_o}, {1'h1, 3'h3});
			end
		join
		@(negedge clk_i);
		chk({gr_write_o, seq_hold_o, gr_data_o, target_register_code_o}, {2'h2, exp_a, 3'h3});
		// mid-run reset returns status bits to rest
		@(posedge clk_i);
		sys_rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		@(negedge clk_i);
		chk({avs_waitrequest_o, ext_inh_o, int_inh_o, float_mode_o, seq_hold_o}, 32'h10);
		ei = 1'h0;
		ii = 1'h0;
		fm = 1'h0;
		// options write without byte lane 0 ignored, then options cleared
		bus(1'h1, rdd_pkg::RDD_REG_OPTIONS, 32'h0, 4'hE);
		bus(1'h0, rdd_pkg::RDD_REG_OPTIONS, 32'h0, 4'hF);
		chk(rd, 32'h7);
		bus(1'h1, rdd_pkg::RDD_REG_OPTIONS, 32'h0, 4'hF);
		issue(16'h1088, 16'h0, 16'h0, 1'h0);
		@(negedge clk_i);
		chk({fault_o, field_cond_o}, 32'h2);
		bus(1'h0, rdd_pkg::RDD_REG_FAULT, 32'h0, 4'hF);
		chk(rd, 32'h88);
		bus(1'h1, rdd_pkg::RDD_REG_OPTIONS, 32'h7, 4'hF);
		end_of_test();
	end
endmodule
